// ==== amd_pkg.sv ====
package amd_pkg;

  // ---------------------------------------------------------------
  // Prebyte codes
  // ---------------------------------------------------------------
  localparam logic [7:0] SECOND_INDEX_PREBYTE = 8'h90;
  localparam logic [7:0] INDIRECT_SECOND_INDEX_PREBYTE = 8'h91;
  localparam logic [7:0] INDIRECT_MODE_PREBYTE = 8'h92;

  // ---------------------------------------------------------------
  // Address ranges and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PAGE_ZERO_LAST = 16'h00ff;
  localparam logic [15:0] SHORT_INDEXED_LAST = 16'h01fe;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] LEN_RESET = 3'h1;

  // ---------------------------------------------------------------
  // Addressing modes and families
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    AM_INHERENT,
    AM_IMMEDIATE,
    AM_DIR_SHORT,
    AM_DIR_LONG,
    AM_IDX_NOOFF,
    AM_IDX_SHORT,
    AM_IDX_LONG,
    AM_IND_SHORT,
    AM_IND_LONG,
    AM_INDIDX_SHORT,
    AM_INDIDX_LONG,
    AM_REL_DIR,
    AM_REL_IND,
    AM_BIT_DIR,
    AM_BIT_IND,
    AM_BITREL_DIR,
    AM_BITREL_IND
  } amd_mode_e;

  typedef enum logic [2:0] {
    AF_INHERENT,
    AF_IMMEDIATE,
    AF_DIRECT,
    AF_INDEXED,
    AF_INDIRECT,
    AF_RELATIVE,
    AF_BIT
  } amd_family_e;

  // Inherent operation classes
  typedef enum logic [3:0] {
    OP_NONE,
    OP_NOP,
    OP_TRAP,
    OP_WAIT_FOR_INTERRUPT,
    OP_HALT,
    OP_RET,
    OP_IRET,
    OP_SET_MASK,
    OP_CLEAR_MASK,
    OP_SET_CARRY,
    OP_CLEAR_CARRY,
    OP_RESET_SP,
    OP_MUL,
    OP_SWAP,
    OP_OTHER
  } amd_inh_op_e;

  typedef struct packed {
    amd_mode_e mode;
    amd_family_e family;
    logic use_second_index;
    logic is_long;
    logic rmw;
    logic [2:0] follow_bytes;
  } amd_class_s;

  typedef struct packed {
    logic [15:0] ea;
    logic [2:0] length;
    amd_mode_e mode;
    amd_family_e family;
    logic use_second_index;
    logic is_long;
    logic rmw;
    amd_inh_op_e inh_op;
    logic illegal;
  } amd_result_s;

endpackage : amd_pkg

// ==== amd_classify.sv ====
`timescale 1ns/100ps
`default_nettype none
module amd_classify
  import amd_pkg::*;
(
  input wire logic [1:0] prebyte_kind,
  input wire logic [7:0] opcode,
  output amd_class_s cls,
  output amd_inh_op_e inh_op,
  output logic illegal
);

  // ---------------------------------------------------------------
  // Opcode column and row
  // ---------------------------------------------------------------
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  // Bytes after the opcode only; a prebyte is counted by the sequencer,
  // so the Y no-offset form grows by its prebyte alone
  function automatic logic [2:0] bytes_of(input amd_mode_e m);
    unique case (m)
      AM_INHERENT: bytes_of = 3'd0;
      AM_IMMEDIATE: bytes_of = 3'd1;
      AM_DIR_SHORT: bytes_of = 3'd1;
      AM_DIR_LONG: bytes_of = 3'd2;
      AM_IDX_NOOFF: bytes_of = 3'd0;
      AM_IDX_SHORT: bytes_of = 3'd1;
      AM_IDX_LONG: bytes_of = 3'd2;
      AM_IND_SHORT: bytes_of = 3'd1;
      AM_IND_LONG: bytes_of = 3'd1;
      AM_INDIDX_SHORT: bytes_of = 3'd1;
      AM_INDIDX_LONG: bytes_of = 3'd1;
      AM_REL_DIR: bytes_of = 3'd1;
      AM_REL_IND: bytes_of = 3'd1;
      AM_BIT_DIR: bytes_of = 3'd1;
      AM_BIT_IND: bytes_of = 3'd1;
      AM_BITREL_DIR: bytes_of = 3'd2;
      AM_BITREL_IND: bytes_of = 3'd2;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Mode from opcode and prebyte
  // ---------------------------------------------------------------
  // prebyte_kind: 0 none, 1 second index, 2 indirect, 3 indirect second
  always_comb begin
    cls.mode = AM_INHERENT;
    cls.family = AF_INHERENT;
    cls.use_second_index = (prebyte_kind == 2'd1) ||
                           (prebyte_kind == 2'd3);
    cls.rmw = 1'b0;
    illegal = 1'b0;
    unique case (hi)
      4'h0: begin
        cls.mode = (prebyte_kind == 2'd2) ? AM_BITREL_IND : AM_BITREL_DIR;
        cls.family = AF_BIT;
        cls.rmw = 1'b1;
      end
      4'h1: begin
        cls.mode = (prebyte_kind == 2'd2) ? AM_BIT_IND : AM_BIT_DIR;
        cls.family = AF_BIT;
        cls.rmw = 1'b1;
      end
      4'h2: begin
        cls.mode = (prebyte_kind == 2'd2) ? AM_REL_IND : AM_REL_DIR;
        cls.family = AF_RELATIVE;
      end
      4'h3: begin
        // Memory read-modify-write: short direct or short indirect only
        cls.mode = (prebyte_kind == 2'd2) ? AM_IND_SHORT : AM_DIR_SHORT;
        cls.family = (prebyte_kind == 2'd2) ? AF_INDIRECT : AF_DIRECT;
        cls.rmw = 1'b1;
      end
      4'h6: begin
        cls.mode = (prebyte_kind[1]) ? AM_INDIDX_SHORT : AM_IDX_SHORT;
        cls.family = (prebyte_kind[1]) ? AF_INDIRECT : AF_INDEXED;
        cls.rmw = 1'b1;
      end
      4'h7: begin
        cls.mode = AM_IDX_NOOFF;
        cls.family = AF_INDEXED;
        cls.rmw = 1'b1;
      end
      4'ha: begin
        cls.mode = AM_IMMEDIATE;
        cls.family = AF_IMMEDIATE;
      end
      4'hb: begin
        cls.mode = (prebyte_kind == 2'd2) ? AM_IND_SHORT : AM_DIR_SHORT;
        cls.family = (prebyte_kind == 2'd2) ? AF_INDIRECT : AF_DIRECT;
      end
      4'hc: begin
        cls.mode = (prebyte_kind == 2'd2) ? AM_IND_LONG : AM_DIR_LONG;
        cls.family = (prebyte_kind == 2'd2) ? AF_INDIRECT : AF_DIRECT;
      end
      4'hd: begin
        cls.mode = (prebyte_kind[1]) ? AM_INDIDX_LONG : AM_IDX_LONG;
        cls.family = (prebyte_kind[1]) ? AF_INDIRECT : AF_INDEXED;
      end
      4'he: begin
        cls.mode = (prebyte_kind[1]) ? AM_INDIDX_SHORT : AM_IDX_SHORT;
        cls.family = (prebyte_kind[1]) ? AF_INDIRECT : AF_INDEXED;
      end
      4'hf: begin
        cls.mode = AM_IDX_NOOFF;
        cls.family = AF_INDEXED;
      end
      default: begin
        // Columns 4, 5, 8, 9: one-byte register and control operations
        cls.mode = AM_INHERENT;
        cls.family = AF_INHERENT;
        illegal = (prebyte_kind[1]); // Indirect has no inherent form
      end
    endcase
    // Indirect prebyte on the no-offset column has no meaning
    if (cls.mode == AM_IDX_NOOFF && prebyte_kind[1]) begin
      illegal = 1'b1;
    end
    cls.is_long = (cls.mode == AM_DIR_LONG) || (cls.mode == AM_IDX_LONG) ||
                  (cls.mode == AM_IND_LONG) ||
                  (cls.mode == AM_INDIDX_LONG);
    cls.follow_bytes = bytes_of(cls.mode);
  end

  // ---------------------------------------------------------------
  // Single-byte operation class
  // ---------------------------------------------------------------
  always_comb begin
    inh_op = OP_NONE;
    if (cls.mode == AM_INHERENT) begin
      inh_op = OP_OTHER;
      unique case (opcode)
        8'h9d: inh_op = OP_NOP;
        8'h83: inh_op = OP_TRAP;
        8'h8f: inh_op = OP_WAIT_FOR_INTERRUPT;
        8'h8e: inh_op = OP_HALT;
        8'h81: inh_op = OP_RET;
        8'h80: inh_op = OP_IRET;
        8'h9b: inh_op = OP_SET_MASK;
        8'h9a: inh_op = OP_CLEAR_MASK;
        8'h99: inh_op = OP_SET_CARRY;
        8'h98: inh_op = OP_CLEAR_CARRY;
        8'h9c: inh_op = OP_RESET_SP;
        8'h42: inh_op = OP_MUL;
        8'h4e: inh_op = OP_SWAP;
        default: inh_op = OP_OTHER;
      endcase
    end
    if (lo == 4'hf && hi == 4'h9) begin
      inh_op = OP_OTHER;
    end
  end

endmodule // amd_classify
`default_nettype wire

// ==== amd_decoder.sv ====
// What this block does
// - Seventeen addressing modes in seven families are decoded.
// - Long forms reach all 64 Kbytes with more bytes and cycles.
// - Short direct and short indirect forms address page zero, 0000h to 00FFh.
// - Read-modify-write memory operations exist only in short forms.
// - Inherent instructions are one byte, nothing follows the opcode.
// - Immediate instructions are opcode plus one operand byte.
// - Direct operand sits at the address carried after the opcode.
// - Short direct takes one address byte reaching 00 to FF.
// - No-offset indexed adds no byte with X, one byte with Y.
// - Relative target is next-instruction PC plus signed byte.
// - One-byte control, flag, stack, multiply and swap ops are recognised.
// - Long direct takes a two-byte address over the full space.
// - Short indexed adds one offset byte, reaching 00 to 1FE.
// - Short indirect fetches a page-zero byte pointer reaching 00 to FF.
// - Prebytes 90, 92, 91 select Y, indirect, and indirect Y.
`timescale 1ns/100ps
`default_nettype none
module amd_decoder
  import amd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] pc,
  input wire logic [7:0] x_reg,
  input wire logic [7:0] y_reg,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data,
  output logic busy,
  output logic done,
  output amd_result_s result
);

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_OPERAND,
    ST_POINTER,
    ST_FINISH
  } amd_state_e;

  amd_state_e state_q;
  logic mem_req_q;
  logic [15:0] mem_addr_q;
  logic [15:0] fetch_pc_q;
  logic [15:0] start_pc_q;
  logic [1:0] prebyte_q;
  logic [7:0] opcode_q;
  logic [2:0] got_q;
  logic [7:0] op1_q;
  logic [7:0] op2_q;
  logic busy_q;
  logic [1:0] ptr_need_q;
  logic [1:0] ptr_got_q;
  logic [15:0] ptr_q;
  logic [15:0] ptr_addr_q;
  logic done_q;
  amd_result_s result_q;

  amd_class_s cls;
  amd_inh_op_e inh_op;
  logic illegal;

  amd_classify u_classify (
    .prebyte_kind(prebyte_q),
    .opcode(opcode_q),
    .cls(cls),
    .inh_op(inh_op),
    .illegal(illegal)
  );

  function automatic logic [1:0] prebyte_of(input logic [7:0] b);
    unique case (b)
      SECOND_INDEX_PREBYTE: prebyte_of = 2'd1;
      INDIRECT_MODE_PREBYTE: prebyte_of = 2'd2;
      INDIRECT_SECOND_INDEX_PREBYTE: prebyte_of = 2'd3;
      default: prebyte_of = 2'd0;
    endcase
  endfunction

  // Unsigned sum, carry kept; never sign extends the offset
  function automatic logic [15:0] idx_sum(input logic [7:0] idx,
                                          input logic [15:0] off);
    idx_sum = off + {8'h00, idx};
  endfunction

  function automatic logic [1:0] ptr_bytes(input amd_mode_e m);
    unique case (m)
      AM_IND_LONG, AM_INDIDX_LONG: ptr_bytes = 2'd2;
      AM_IND_SHORT, AM_INDIDX_SHORT, AM_REL_IND,
      AM_BIT_IND, AM_BITREL_IND: ptr_bytes = 2'd1;
      default: ptr_bytes = 2'd0;
    endcase
  endfunction

  logic [7:0] index;
  logic [15:0] pc_next;
  assign index = cls.use_second_index ? y_reg : x_reg;
  // Prebyte plus opcode plus what follows
  assign pc_next = start_pc_q + 16'(prebyte_q != 2'd0) + 16'd1 +
                   16'(cls.follow_bytes);

  // ---------------------------------------------------------------
  // Effective address
  // ---------------------------------------------------------------
  logic [15:0] ea;
  logic [15:0] rel_off;
  always_comb begin
    ea = ADDR_RESET;
    rel_off = 16'h0000;
    unique case (cls.mode)
      AM_INHERENT, AM_IMMEDIATE: ea = ADDR_RESET;
      AM_DIR_SHORT, AM_BIT_DIR, AM_BITREL_DIR:
        ea = {8'h00, op1_q};
      AM_DIR_LONG: ea = {op1_q, op2_q};
      AM_IDX_NOOFF: ea = {8'h00, index};
      AM_IDX_SHORT: ea = idx_sum(index, {8'h00, op1_q});
      AM_IDX_LONG: ea = idx_sum(index, {op1_q, op2_q});
      AM_IND_SHORT, AM_BIT_IND, AM_BITREL_IND:
        ea = {8'h00, ptr_q[7:0]};
      AM_IND_LONG: ea = ptr_q;
      AM_INDIDX_SHORT: ea = idx_sum(index, {8'h00, ptr_q[7:0]});
      AM_INDIDX_LONG: ea = idx_sum(index, ptr_q);
      AM_REL_DIR: begin
        rel_off = {{8{op1_q[7]}}, op1_q};
        ea = pc_next + rel_off;
      end
      AM_REL_IND: begin
        rel_off = {{8{ptr_q[7]}}, ptr_q[7:0]};
        ea = pc_next + rel_off;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Fetch sequencer
  // ---------------------------------------------------------------
  // One byte fetch outstanding at a time; memory answers with mem_valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      mem_req_q <= 1'b0;
      mem_addr_q <= ADDR_RESET;
      fetch_pc_q <= ADDR_RESET;
      start_pc_q <= ADDR_RESET;
      prebyte_q <= 2'd0;
      opcode_q <= BYTE_RESET;
      got_q <= 3'd0;
      op1_q <= BYTE_RESET;
      op2_q <= BYTE_RESET;
      ptr_need_q <= 2'd0;
      ptr_got_q <= 2'd0;
      ptr_q <= ADDR_RESET;
      ptr_addr_q <= ADDR_RESET;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_OPCODE;
            start_pc_q <= pc;
            fetch_pc_q <= pc + 16'd1;
            mem_addr_q <= pc;
            mem_req_q <= 1'b1;
            prebyte_q <= 2'd0;
          end
        end
        ST_OPCODE: begin
          if (mem_valid) begin
            mem_addr_q <= fetch_pc_q;
            fetch_pc_q <= fetch_pc_q + 16'd1;
            if (prebyte_q == 2'd0 && prebyte_of(mem_data) != 2'd0) begin
              prebyte_q <= prebyte_of(mem_data);
            end else begin
              opcode_q <= mem_data;
              got_q <= 3'd0;
              state_q <= ST_OPERAND;
              mem_req_q <= 1'b0;
            end
          end
        end
        ST_OPERAND: begin
          // Classifier sees the latched opcode from this cycle on
          if (got_q == cls.follow_bytes) begin
            ptr_need_q <= ptr_bytes(cls.mode);
            ptr_got_q <= 2'd0;
            ptr_addr_q <= {8'h00, op1_q};
            if (ptr_bytes(cls.mode) != 2'd0) begin
              state_q <= ST_POINTER;
              mem_addr_q <= {8'h00, op1_q};
              mem_req_q <= 1'b1;
            end else begin
              state_q <= ST_FINISH;
              mem_req_q <= 1'b0;
            end
          end else if (!mem_req_q) begin
            mem_req_q <= 1'b1;
          end else if (mem_valid) begin
            unique case (got_q)
              3'd0: op1_q <= mem_data;
              default: op2_q <= mem_data;
            endcase
            got_q <= got_q + 3'd1;
            mem_addr_q <= fetch_pc_q;
            fetch_pc_q <= fetch_pc_q + 16'd1;
            mem_req_q <= 1'b0;
          end
        end
        ST_POINTER: begin
          // Pointer is stored high byte first in page zero
          if (mem_valid) begin
            ptr_q <= (ptr_need_q == 2'd2) ? {ptr_q[7:0], mem_data}
                                          : {8'h00, mem_data};
            ptr_got_q <= ptr_got_q + 2'd1;
            ptr_addr_q <= ptr_addr_q + 16'd1;
            mem_addr_q <= ptr_addr_q + 16'd1;
            if (ptr_got_q + 2'd1 == ptr_need_q) begin
              state_q <= ST_FINISH;
              mem_req_q <= 1'b0;
            end
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
          mem_req_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Result register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      result_q <= '0;
    end else begin
      done_q <= (state_q == ST_FINISH);
      if (state_q == ST_FINISH) begin
        result_q.ea <= ea;
        result_q.length <= 3'(pc_next - start_pc_q);
        result_q.mode <= cls.mode;
        result_q.family <= cls.family;
        result_q.use_second_index <= cls.use_second_index;
        result_q.is_long <= cls.is_long;
        result_q.rmw <= cls.rmw && !cls.is_long;
        result_q.inh_op <= inh_op;
        result_q.illegal <= illegal;
      end
    end
  end

  // Busy mirrors the next state so that it leaves a flip-flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      busy_q <= start;
    end else begin
      busy_q <= (state_q != ST_FINISH);
    end
  end

  assign mem_req = mem_req_q;
  assign mem_addr = mem_addr_q;
  assign busy = busy_q;
  assign done = done_q;
  assign result = result_q;

endmodule // amd_decoder
`default_nettype wire

// ==== amd_decoder_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_assertions
  import amd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] pc,
  input wire logic [7:0] x_reg,
  input wire logic [7:0] y_reg,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data,
  input wire logic busy,
  input wire logic done,
  input wire amd_result_s result
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Launch and fetch
  // ---------------------------------------------------------------
  sequence launch_s;
    start && !busy;
  endsequence
  sequence fetch_s;
    mem_req && busy ##1 busy [*2];
  endsequence

  start_fetch_a: assert property (launch_s |=> mem_req &&
    mem_addr == $past(pc)) else $error("first fetch not at pc");
  launch_busy_a: assert property (launch_s |=> fetch_s)
    else $error("fetch did not stay busy");
  req_hold_a: assert property (mem_req && !mem_valid |=>
    mem_req && $stable(mem_addr)) else $error("request dropped early");
  done_gap_a: assert property (done |=> !done [*3])
    else $error("done pulses too close");
  result_hold_a: assert property (!done |-> $stable(result))
    else $error("result changed without done");

  // ---------------------------------------------------------------
  // Lengths and reach of the finished decode
  // ---------------------------------------------------------------
  inh_len_a: assert property (done && result.family == AF_INHERENT &&
    !result.use_second_index && !result.illegal |-> result.length == 3'h1)
    else $error("inherent length wrong");
  imm_len_a: assert property (done && result.mode == AM_IMMEDIATE &&
    !result.use_second_index |-> result.length == 3'h2)
    else $error("immediate length wrong");
  dir_page_a: assert property (done && result.mode == AM_DIR_SHORT |->
    result.ea <= PAGE_ZERO_LAST && !result.is_long)
    else $error("short direct outside page zero");
  idx_range_a: assert property (done && result.mode == AM_IDX_SHORT |->
    result.ea <= SHORT_INDEXED_LAST) else $error("short indexed too far");
  nooff_len_a: assert property (done && result.mode == AM_IDX_NOOFF |->
    result.length == (result.use_second_index ? 3'h2 : 3'h1))
    else $error("no-offset length wrong");
  long_len_a: assert property (done && !result.use_second_index &&
    (result.mode == AM_DIR_LONG || result.mode == AM_IDX_LONG) |->
    result.length == 3'h3 && result.is_long) else $error("long length wrong");
  rmw_short_a: assert property (done && result.rmw |-> !result.is_long)
    else $error("rmw in long form");
  ind_short_a: assert property (done && result.mode == AM_IND_SHORT |->
    result.length == 3'h3 && result.ea <= PAGE_ZERO_LAST)
    else $error("short indirect wrong");
endmodule // amd_decoder_assertions
`default_nettype wire

// ==== amd_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module amd_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [1:0] lat,
  output logic mem_valid,
  output logic [7:0] mem_data
);
  logic [7:0] mem [0:65535];
  logic served_q;
  logic [15:0] served_addr_q;
  logic fresh;
  logic [1:0] cnt_q;

  // A new address under a standing mem_req is a new request
  assign fresh = mem_req && (!served_q || mem_addr != served_addr_q);

  // One answer per request; data is scrambled outside the answer cycle
  // so the decoder cannot live on a stale byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_valid <= 1'b0;
      mem_data <= 8'h00;
      served_q <= 1'b0;
      served_addr_q <= 16'h0000;
      cnt_q <= 2'h0;
    end else if (fresh && cnt_q >= lat) begin
      mem_valid <= 1'b1;
      mem_data <= mem[mem_addr];
      served_q <= 1'b1;
      served_addr_q <= mem_addr;
      cnt_q <= 2'h0;
    end else begin
      mem_valid <= 1'b0;
      mem_data <= ~mem_data;
      if (!mem_req) served_q <= 1'b0;
      else if (fresh) cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule // amd_mem_model
`default_nettype wire

// ==== amd_decoder_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_bench;
  import amd_pkg::*;
  typedef struct packed {
    amd_result_s r;
    logic [1:0] lvl;
  } amd_note_s;
  logic clk, rst, start, mem_req, mem_valid, busy, done;
  logic [15:0] pc, mem_addr, p;
  logic [7:0] x_reg, y_reg, mem_data, a, h, q;
  logic [3:0] n;
  logic [1:0] lat;
  logic [31:0] rnd;
  amd_result_s result;
  amd_note_s exp_q[$];
  amd_note_s nt;
  amd_note_s e1;
  int num_errors = 0;
  int comparisons = 0;
  int k;

  amd_decoder uut (.clk(clk), .rst(rst), .start(start), .pc(pc),
    .x_reg(x_reg), .y_reg(y_reg), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_valid(mem_valid), .mem_data(mem_data), .busy(busy), .done(done),
    .result(result));
  amd_mem_model mm (.clk(clk), .rst(rst), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_valid(mem_valid),
    .mem_data(mem_data));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Level 0 checks all but rmw, 1 also skips ea, 2 checks only rmw
  function automatic amd_note_s mk(input amd_mode_e m, input amd_family_e f,
    input logic [2:0] len, input logic [15:0] ea, input logic y2,
    input logic lg, input logic [1:0] lvl);
    mk = '0;
    mk.r.mode = m;
    mk.r.family = f;
    mk.r.length = len;
    mk.r.ea = ea;
    mk.r.use_second_index = y2;
    mk.r.is_long = lg;
    mk.r.rmw = (lvl == 2'h2);
    mk.lvl = lvl;
  endfunction

  task check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task stop_test;
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // A second start while busy must be ignored
  task go(input logic [15:0] pa, input amd_note_s e);
    int i;
    exp_q.push_back(e);
    @(negedge clk);
    pc = pa;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk);
    if (i == 200) check("done", 16'h0, 16'h1);
  endtask

  task ins(input logic [7:0] b0, b1, b2, input amd_note_s e);
    mm.mem[p] = b0;
    mm.mem[p + 16'h1] = b1;
    mm.mem[p + 16'h2] = b2;
    go(p, e);
  endtask

  // ---------------------------------------------------------------
  // Result watcher
  // ---------------------------------------------------------------
  always begin
    @(posedge clk);
    #1;
    if (done === 1'b1) begin
      if (exp_q.size() == 0) check("spare_done", 16'h1, 16'h0);
      else begin
        nt = exp_q.pop_front();
        if (nt.lvl != 2'h2) begin
          check("mode", {11'h0, result.mode}, {11'h0, nt.r.mode});
          check("family", {13'h0, result.family},
            {13'h0, nt.r.family});
          check("length", {13'h0, result.length},
            {13'h0, nt.r.length});
          check("second_index", {15'h0, result.use_second_index},
            {15'h0, nt.r.use_second_index});
          check("is_long", {15'h0, result.is_long},
            {15'h0, nt.r.is_long});
          check("illegal", {15'h0, result.illegal},
            {15'h0, nt.r.illegal});
          check("inh_op", {12'h0, result.inh_op},
            {12'h0, nt.r.inh_op});
        end
        if (nt.lvl == 2'h0) check("ea", result.ea, nt.r.ea);
        if (nt.lvl == 2'h2) check("rmw", {15'h0, result.rmw}, 16'h1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    pc = 16'h0000;
    x_reg = 8'h00;
    y_reg = 8'h00;
    lat = 2'h0;
    rnd = 32'he6a5;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("reset", {13'h0, mem_req, busy, done}, 16'h0);
    check("reset_result", result.ea, ADDR_RESET);
    rst = 1'b0;
    for (k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      lat = rnd[1:0];
      x_reg = rnd[15:8];
      y_reg = rnd[23:16];
      a = rnd[7:0];
      h = rnd[31:24];
      n = rnd[27:24];
      q = {1'b0, rnd[22:16]};
      p = {4'h8, rnd[11:0]};
      if (k == 0) begin
        x_reg = 8'hff;
        y_reg = 8'hff;
        a = 8'hff;
      end
      e1 = mk(AM_INHERENT, AF_INHERENT, 1, 0, 0, 0, 1);
      e1.r.inh_op = (n == 4'h2) ? OP_MUL : (n == 4'he) ? OP_SWAP : OP_OTHER;
      ins({4'h4, n}, a, a, e1);
      ins({4'ha, n}, a, a, mk(AM_IMMEDIATE, AF_IMMEDIATE, 2, 0, 0, 0, 1));
      ins({4'hb, n}, a, a, mk(AM_DIR_SHORT, AF_DIRECT, 2,
        {8'h0, a}, 0, 0, 0));
      ins({4'hc, n}, h, a, mk(AM_DIR_LONG, AF_DIRECT, 3, {h, a}, 0, 1, 0));
      ins({4'hd, n}, h, a, mk(AM_IDX_LONG, AF_INDEXED, 3,
        {h, a} + {8'h0, x_reg}, 0, 1, 0));
      ins({4'he, n}, a, a, mk(AM_IDX_SHORT, AF_INDEXED, 2,
        {8'h0, a} + {8'h0, x_reg}, 0, 0, 0));
      ins({4'hf, n}, a, a, mk(AM_IDX_NOOFF, AF_INDEXED, 1,
        {8'h0, x_reg}, 0, 0, 0));
      ins(8'h90, {4'hf, n}, a, mk(AM_IDX_NOOFF, AF_INDEXED, 2,
        {8'h0, y_reg}, 1, 0, 0));
      ins(8'h90, {4'he, n}, a, mk(AM_IDX_SHORT, AF_INDEXED, 3,
        {8'h0, a} + {8'h0, y_reg}, 1, 0, 0));
      ins({4'h2, n}, a, a, mk(AM_REL_DIR, AF_RELATIVE, 2,
        p + 16'h2 + {{8{a[7]}}, a}, 0, 0, 0));
      ins({4'h1, n}, a, a, mk(AM_BIT_DIR, AF_BIT, 2, {8'h0, a}, 0, 0, 0));
      ins({4'h0, n}, a, a, mk(AM_BITREL_DIR, AF_BIT, 3, 0, 0, 0, 1));
      ins({4'h3, n}, a, a, mk(AM_INHERENT, AF_INHERENT, 0, 0, 0, 0, 2));
      // A second prebyte is taken as the opcode
      e1 = mk(AM_INHERENT, AF_INHERENT, 2, 0, 1, 0, 1);
      e1.r.inh_op = OP_OTHER;
      ins(8'h90, 8'h90, a, e1);
      mm.mem[{8'h0, q}] = h;
      mm.mem[{8'h0, q} + 16'h1] = a;
      ins(8'h92, {4'hb, n}, q, mk(AM_IND_SHORT, AF_INDIRECT, 3,
        {8'h0, h}, 0, 0, 0));
      ins(8'h92, {4'hc, n}, q, mk(AM_IND_LONG, AF_INDIRECT, 3,
        {h, a}, 0, 1, 0));
      ins(8'h92, {4'he, n}, q, mk(AM_INDIDX_SHORT, AF_INDIRECT, 3,
        {8'h0, h} + {8'h0, x_reg}, 0, 0, 0));
      ins(8'h91, {4'he, n}, q, mk(AM_INDIDX_SHORT, AF_INDIRECT, 3,
        {8'h0, h} + {8'h0, y_reg}, 1, 0, 0));
    end
    e1 = mk(AM_INHERENT, AF_INHERENT, 1, 0, 0, 0, 1);
    e1.r.inh_op = OP_WAIT_FOR_INTERRUPT;
    ins(8'h8f, a, a, e1);
    e1.r.inh_op = OP_NOP;
    ins(8'h9d, a, a, e1);
    // Indirect prebyte ahead of a one-byte opcode is flagged
    e1.r.length = 3'h2;
    e1.r.illegal = 1'b1;
    ins(8'h92, 8'h9d, a, e1);
    repeat (4) @(negedge clk);
    check("pending", exp_q.size(), 16'h0);
    stop_test;
  end
endmodule // amd_decoder_bench

bind amd_decoder amd_decoder_assertions chk (.clk(clk), .rst(rst),
  .start(start), .pc(pc), .x_reg(x_reg), .y_reg(y_reg),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_valid(mem_valid),
  .mem_data(mem_data), .busy(busy), .done(done), .result(result));
`default_nettype wire
